// File: core/codec_port_pkg.sv
// Constants shared by the companding codec serial port.
// Assumes a 100 MHz core clock and bit clocks far slower than it.
package codec_port_pkg;
	// ---------------------------------------------------------------
	// Code word layout
	// ---------------------------------------------------------------
	localparam int WORD_BITS   = 8;
	localparam int SIGN_POS    = 7;
	localparam int SEG_MSB     = 6;
	localparam int SEG_LSB     = 4;
	localparam int LEVEL_MSB   = 3;
	localparam int LEVEL_LSB   = 0;
	localparam logic [2:0] BIT_CNT_LAST = 3'h7;
	localparam logic [2:0] BIT_CNT_ZERO = 3'h0;
	localparam logic [7:0] IDLE_WORD    = 8'h00;
	// ---------------------------------------------------------------
	// Conversion timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 10;
	localparam int NULL_TIME_NS    = 100;
	localparam int NULL_CYCLES     = (NULL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] NULL_CNT_LAST = 8'(NULL_CYCLES - 1);
	localparam logic [7:0] CNT_ZERO      = 8'h00;
	localparam logic [7:0] CNT_ONE       = 8'h01;
	localparam logic       BUF_PTR_ONE   = 1'b1;
	localparam logic [1:0] BUF_CNT_ONE   = 2'h1;
	localparam logic [1:0] BUF_CNT_TWO   = 2'h2;
	localparam logic [1:0] BUF_CNT_ZERO  = 2'h0;
endpackage

// File: core/mulaw_codec_serial_port.sv
// Serial framing logic of a companding voice codec, transmit and receive.
// Assumes strobes and bit clocks come from a remote highway controller,
// asynchronous to core_clk, and much slower than it.
`timescale 1ns/1ps
// How it works
// - An offset null cycle runs before every conversion.
// - Sign bit is excluded from offset nulling, stays stable at zero input.
// - Word is sign, three segment bits, four level bits.
// - Sign one is positive, zero negative; magnitude from segment and level.
// - First received bit taken when strobe and bit clock are both high.
// - Core clock and both bit clocks are mutually independent.
// - Rising transmit strobe enables output, starts conversion; falling releases it.
// - Eight bits shifted in while strobe high; word delivered after it falls.
module mulaw_codec_serial_port
	import codec_port_pkg::*;
#(
	parameter int NULL_LEN = NULL_CYCLES
) (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       tx_frame_strobe,
	input  wire logic       tx_bit_clock,
	input  wire logic       rx_frame_strobe,
	input  wire logic       rx_bit_clock,
	input  wire logic       rx_data,
	output logic            tx_data_out,
	output logic            tx_data_oe_n,
	input  wire logic [7:0] adc_code,
	input  wire logic       adc_sign_raw,
	output logic            null_active,
	output logic            conv_start,
	output logic [7:0]      dac_code,
	output logic            dac_valid,
	input  wire logic       dac_ready
);
	// ---------------------------------------------------------------
	// Input synchronisers: three stages; strobes and clocks change once stages 2 and 3 agree
	// ---------------------------------------------------------------
	logic [2:0] txs_reg, txc_reg, rxs_reg, rxc_reg, rxd_reg;
	logic       txs_q_reg, txc_q_reg, rxs_q_reg, rxc_q_reg;
	// Stage one only feeds stage two, keeping metastability contained
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			txs_reg <= 3'h0;
			txc_reg <= 3'h0;
			rxs_reg <= 3'h0;
			rxc_reg <= 3'h0;
			rxd_reg <= 3'h0;
		end else begin
			txs_reg <= {txs_reg[1:0], tx_frame_strobe};
			txc_reg <= {txc_reg[1:0], tx_bit_clock};
			rxs_reg <= {rxs_reg[1:0], rx_frame_strobe};
			rxc_reg <= {rxc_reg[1:0], rx_bit_clock};
			rxd_reg <= {rxd_reg[1:0], rx_data};
		end
	end
	// Filtered levels: hold until stages two and three agree
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			txs_q_reg <= 1'b0;
			txc_q_reg <= 1'b0;
			rxs_q_reg <= 1'b0;
			rxc_q_reg <= 1'b0;
		end else begin
			if (txs_reg[1] == txs_reg[2]) txs_q_reg <= txs_reg[2];
			if (txc_reg[1] == txc_reg[2]) txc_q_reg <= txc_reg[2];
			if (rxs_reg[1] == rxs_reg[2]) rxs_q_reg <= rxs_reg[2];
			if (rxc_reg[1] == rxc_reg[2]) rxc_q_reg <= rxc_reg[2];
		end
	end
	wire txs_f = (txs_reg[1] == txs_reg[2]) ? txs_reg[2] : txs_q_reg;
	wire txc_f = (txc_reg[1] == txc_reg[2]) ? txc_reg[2] : txc_q_reg;
	wire rxs_f = (rxs_reg[1] == rxs_reg[2]) ? rxs_reg[2] : rxs_q_reg;
	wire rxc_f = (rxc_reg[1] == rxc_reg[2]) ? rxc_reg[2] : rxc_q_reg;
	// Edge events on the filtered levels
	wire tx_start = txs_f & ~txs_q_reg;
	wire tx_end   = ~txs_f & txs_q_reg;
	wire tx_rise  = txc_f & ~txc_q_reg;
	wire rx_end   = ~rxs_f & rxs_q_reg;
	// First bit: strobe rising while clock already high counts as the edge
	wire rx_take  = rxs_f & ((rxc_f & ~rxc_q_reg) | (rxc_f & ~rxs_q_reg));
	// ---------------------------------------------------------------
	// Transmit: null cycle, conversion, load, shift
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {TX_IDLE, TX_NULL, TX_LOAD, TX_SHIFT} tx_state_t;
	tx_state_t  tx_state_reg;
	logic [7:0] null_cnt_reg;
	logic [7:0] tx_shift_reg;
	logic       sign_hold_reg;
	logic       oe_reg;
	wire        null_done = (null_cnt_reg == 8'(NULL_LEN - 1));
	// Sign sampled outside the null cycle; magnitude from the converter
	wire [7:0]  conv_word = {sign_hold_reg, adc_code[SEG_MSB:LEVEL_LSB]};
	// Sequencer; load precedes any shift so a frame never mixes two words
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_state_reg  <= TX_IDLE;
			null_cnt_reg  <= CNT_ZERO;
			tx_shift_reg  <= IDLE_WORD;
			sign_hold_reg <= 1'b0;
			oe_reg        <= 1'b0;
		end else begin
			case (tx_state_reg)
				TX_IDLE: begin
					null_cnt_reg <= CNT_ZERO;
					if (tx_start) begin
						oe_reg        <= 1'b1;
						sign_hold_reg <= adc_sign_raw;
						tx_state_reg  <= TX_NULL;
					end
				end
				TX_NULL: begin
					null_cnt_reg <= null_cnt_reg + CNT_ONE;
					if (null_done) tx_state_reg <= TX_LOAD;
				end
				TX_LOAD: begin
					tx_shift_reg <= conv_word;
					tx_state_reg <= TX_SHIFT;
				end
				default: begin
					if (tx_rise) tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
				end
			endcase
			if (tx_end) begin
				oe_reg       <= 1'b0;
				tx_state_reg <= TX_IDLE;
			end
		end
	end
	// Serial output and its enable; the data bit holds between recognised bit clock rises.
	// Enable is a register so the released pin never glitches on strobe noise.
	assign tx_data_out  = tx_shift_reg[SIGN_POS];
	assign tx_data_oe_n = ~oe_reg;
	assign null_active  = (tx_state_reg == TX_NULL);
	assign conv_start   = tx_start;
	// ---------------------------------------------------------------
	// Receive: shift while strobe high, deliver on falling strobe
	// ---------------------------------------------------------------
	logic [7:0] rx_shift_reg;
	logic [2:0] rx_cnt_reg;
	logic       rx_full_reg;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_shift_reg <= IDLE_WORD;
			rx_cnt_reg   <= BIT_CNT_ZERO;
			rx_full_reg  <= 1'b0;
		end else if (rx_end) begin
			rx_cnt_reg  <= BIT_CNT_ZERO;
			rx_full_reg <= 1'b0;
		end else if (rx_take && !rx_full_reg) begin
			rx_shift_reg <= {rx_shift_reg[6:0], rxd_reg[2]};
			rx_cnt_reg   <= rx_cnt_reg + 3'h1;
			if (rx_cnt_reg == BIT_CNT_LAST) rx_full_reg <= 1'b1;
		end
	end
	// Word offered to the buffer only if all eight bits arrived
	// A cut frame leaves nothing behind: the count restarts on every strobe fall
	wire rx_push = rx_end & rx_full_reg;
	// ---------------------------------------------------------------
	// Two-entry buffer toward the converter; a stall keeps two words, a third is dropped
	// ---------------------------------------------------------------
	logic [7:0] buf_mem [2];
	logic       wr_ptr_reg, rd_ptr_reg;
	logic [1:0] buf_cnt_reg;
	// Full buffer drops a new word: the frame source cannot be stalled
	wire buf_in  = rx_push & (buf_cnt_reg != BUF_CNT_TWO);
	wire buf_out = dac_valid & dac_ready;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_reg  <= 1'b0;
			rd_ptr_reg  <= 1'b0;
			buf_cnt_reg <= BUF_CNT_ZERO;
			buf_mem[0]  <= IDLE_WORD;
			buf_mem[1]  <= IDLE_WORD;
		end else begin
			if (buf_in) begin
				buf_mem[wr_ptr_reg] <= rx_shift_reg;
				wr_ptr_reg          <= wr_ptr_reg ^ BUF_PTR_ONE;
			end
			if (buf_out) rd_ptr_reg <= rd_ptr_reg ^ BUF_PTR_ONE;
			if (buf_in && !buf_out) buf_cnt_reg <= buf_cnt_reg + BUF_CNT_ONE;
			else if (!buf_in && buf_out) buf_cnt_reg <= buf_cnt_reg - BUF_CNT_ONE;
		end
	end
	assign dac_valid = (buf_cnt_reg != BUF_CNT_ZERO);
	assign dac_code  = buf_mem[rd_ptr_reg];
	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_null_before_load: assert property (@(posedge core_clk) disable iff (!arst_n)
		(tx_state_reg == TX_LOAD) |-> $past(tx_state_reg) == TX_NULL)
		else $error("load without null cycle");
	a_oe_on_start: assert property (@(posedge core_clk) disable iff (!arst_n)
		tx_start |=> !tx_data_oe_n)
		else $error("output not enabled on strobe");
	a_oe_off_end: assert property (@(posedge core_clk) disable iff (!arst_n)
		tx_end |=> tx_data_oe_n)
		else $error("output not released on strobe fall");
	a_load_word: assert property (@(posedge core_clk) disable iff (!arst_n)
		(tx_state_reg == TX_LOAD && !tx_end) |=> tx_shift_reg == $past(conv_word))
		else $error("shifter not loaded with converted word");
	a_sign_stable: assert property (@(posedge core_clk) disable iff (!arst_n)
		(tx_state_reg == TX_NULL) |=> $stable(sign_hold_reg))
		else $error("sign changed during null cycle");
	a_rx_eight_bits: assert property (@(posedge core_clk) disable iff (!arst_n)
		rx_push |-> rx_cnt_reg == BIT_CNT_ZERO)
		else $error("word delivered without eight bits");
	a_rx_shift_msb: assert property (@(posedge core_clk) disable iff (!arst_n)
		(rx_take && !rx_full_reg && !rx_end) |=> rx_shift_reg[0] == $past(rxd_reg[2]))
		else $error("received bit not captured");
	a_buf_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
		(dac_valid && !dac_ready) |=> dac_valid && $stable(dac_code))
		else $error("buffered word lost under stall");
endmodule

// File: sim/highway_ctrl_model.sv
// Behavioural highway controller: strobes, bit clocks and serial input.
// Assumes callers start tasks off core clock edges; clocks stop between frames.
`timescale 1ns/1ps
module highway_ctrl_model (
	output logic tx_frame_strobe,
	output logic tx_bit_clock,
	output logic rx_frame_strobe,
	output logic rx_bit_clock,
	output logic rx_data,
	input  wire logic tx_data_out,
	input  wire logic tx_data_oe_n
);
	initial begin
		{tx_frame_strobe, tx_bit_clock, rx_frame_strobe, rx_bit_clock, rx_data} = '0;
	end
	// ------------------------------------------------------------
	// Transmit frame, eight bits collected sign first
	// ------------------------------------------------------------
	task automatic take_word(output logic [7:0] word, output logic oe_mid);
		tx_frame_strobe = 1'b1;
		#200; // Room for null and load before first edge
		word[7] = tx_data_out;
		oe_mid = tx_data_oe_n;
		for (int i = 6; i >= 0; i--) begin
			tx_bit_clock = 1'b1; // One fixed bit clock period for the whole run
			#62.5;
			tx_bit_clock = 1'b0;
			#62.5;
			word[i] = tx_data_out;
		end
		tx_frame_strobe = 1'b0; // Strobe returns low after each word
		#20; // Low gap of more than one core clock
	endtask
	// ------------------------------------------------------------
	// Receive frame of n bits, first bit in bits[8]
	// ------------------------------------------------------------
	task automatic give_word(input logic [8:0] bits, input int n, input bit early);
		if (early) begin
			rx_data      = bits[8];
			rx_bit_clock = 1'b1; // Clock already high: strobe rise takes bit one
			#62.5;
		end
		rx_frame_strobe = 1'b1;
		for (int i = 0; i < n; i++) begin
			rx_data = bits[8-i];
			#62.5;
			rx_bit_clock = 1'b1;
			#62.5;
			rx_bit_clock = 1'b0;
		end
		#62.5;
		rx_frame_strobe = 1'b0; // Dropped after the word
		rx_data = ~rx_data; // Released line shows no stale bit
		#200; // Low for more than 17 core clocks
	endtask
endmodule

// File: sim/test_mulaw_codec_serial_port.sv
// Self-checking bench for the codec serial port with a highway model.
// Assumes the package and design sources are compiled first.
`timescale 1ns/1ps
module test_mulaw_codec_serial_port;
	import codec_port_pkg::*;
	localparam int NL = 2; // Short null keeps frames brief
	logic core_clk, arst_n, txs, txc, rxs, rxc, rxd, tx_d, oe_n, sign, nul, cst, dv, rdy, stall;
	logic [7:0] code, dcode, w, txw;
	logic oe;
	logic [7:0] exp_q[$];
	int bad_count, samples_checked, seed, null_cnt, start_cnt;
	mulaw_codec_serial_port #(.NULL_LEN(NL)) dut (.core_clk(core_clk), .arst_n(arst_n),
		.tx_frame_strobe(txs), .tx_bit_clock(txc), .rx_frame_strobe(rxs),
		.rx_bit_clock(rxc), .rx_data(rxd), .tx_data_out(tx_d), .tx_data_oe_n(oe_n),
		.adc_code(code), .adc_sign_raw(sign), .null_active(nul), .conv_start(cst),
		.dac_code(dcode), .dac_valid(dv), .dac_ready(rdy));
	highway_ctrl_model hw (.tx_frame_strobe(txs), .tx_bit_clock(txc),
		.rx_frame_strobe(rxs), .rx_bit_clock(rxc), .rx_data(rxd),
		.tx_data_out(tx_d), .tx_data_oe_n(oe_n));
	function automatic logic [7:0] exp_tx(input logic s, input logic [7:0] c);
		return {s, c[6:0]};
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
		samples_checked++;
		if (seen !== want) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic stop_test();
		$display("mismatches %0d checks %0d", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Clock, consumer and activity counters
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (nul === 1'b1) null_cnt++;
		if (cst === 1'b1) start_cnt++;
		if (dv === 1'b1 && rdy === 1'b1) begin
			if (exp_q.size() == 0) check("dac_extra", 8'h01, 8'h00);
			else check("dac_code", dcode, exp_q.pop_front());
		end
		#1 rdy = stall ? 1'b0 : 1'($random(seed)); // Random stalls by consumer
	end
	initial begin
		#200000;
		bad_count++;
		stop_test();
	end
	// ------------------------------------------------------------
	// Main sequence: transmit and receive run side by side
	// ------------------------------------------------------------
	initial begin
		{arst_n, sign, rdy, stall, bad_count, samples_checked} = '0;
		code = 8'h00;
		seed = 39675;
		repeat (2) @(posedge core_clk);
		#1 arst_n = 1'b1;
		fork
			for (int f = 0; f < 6; f++) begin
				code = f < 2 ? 8'h00 : f == 2 ? 8'hff : 8'($random(seed));
				sign = f < 2 ? 1'b0 : 1'($random(seed)); // Zero input twice first
				{null_cnt, start_cnt} = '0;
				hw.take_word(txw, oe);
				check("tx_word", txw, exp_tx(sign, code));
				check("oe_mid", 8'(oe), 8'h00);
				check("null_len", 8'(null_cnt), 8'(NL));
				check("starts", 8'(start_cnt), 8'h01);
				repeat (6) @(posedge core_clk);
				#1 check("oe_idle", 8'(oe_n), 8'h01);
			end
			for (int f = 0; f < 8; f++) begin
				w = f == 0 ? 8'h00 : f == 1 ? 8'hff : 8'($random(seed));
				if (f != 2) exp_q.push_back(w); // Five-bit word is discarded
				hw.give_word({w, ~w[0]}, f == 2 ? 5 : f == 3 ? 9 : 8, f == 4);
			end
		join
		// Drain earlier words so the stall phase starts from an empty buffer
		wait (exp_q.size() == 0);
		@(posedge core_clk);
		#1 stall = 1'b1;
		for (int f = 0; f < 3; f++) begin
			w = 8'($random(seed));
			if (f < 2) exp_q.push_back(w); // Third push finds the buffer full
			hw.give_word({w, 1'b0}, 8, 1'b0);
		end
		check("dac_valid", 8'(dv), 8'h01);
		stall = 1'b0;
		repeat (40) @(posedge core_clk);
		check("left_words", 8'(exp_q.size()), 8'h00);
		stop_test();
	end
endmodule
